// >>> logic/nvc_access.sv
// configuration-space and program memory access sequencer
//
// Functional notes
// - select bit set routes reads and writes to the configuration region
// - configuration region is the bit-15-set address space, partly open
// - read of a non-readable configuration address clears both data bytes
// - user ID words 8000h-8003h are readable and writable
// - per-address read/write rights; device ID 8006h is read-only
// - configuration words 8007h-8008h readable, writes rejected
`timescale 1ns/1ps
`default_nettype none

module nvc_access #(
	// arbitrary neutral identification value
	parameter logic [13:0] DEVICE_ID = 14'h0000
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic reset_n_in,
	// control from the core
	input wire logic config_space_select_in,
	input wire logic read_start_in,
	input wire logic write_start_in,
	input wire logic erase_start_in,
	input wire logic [14:0] addr_in,
	input wire logic [13:0] wdata_in,
	// configuration words from fuse logic
	input wire logic [13:0] cfg_word1_in,
	input wire logic [13:0] cfg_word2_in,
	// flash macro
	input wire logic flash_done_in,
	input wire logic [13:0] flash_rdata_in,
	output logic flash_req_out,
	output logic [1:0] flash_cmd_out,
	output logic [14:0] flash_addr_out,
	output logic [13:0] flash_wdata_out,
	// status and read data to the core
	output logic [5:0] nvm_data_high_out,
	output logic [7:0] nvm_data_low_out,
	output logic busy_out,
	output logic write_reject_out
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		nvc_pkg::nvc_state_e st;
		logic [5:0] dh;
		logic [7:0] dl;
		logic busy;
		logic rej;
		logic req;
		logic [1:0] cmd;
		logic [14:0] faddr;
		logic [13:0] fwd;
		logic [3:0][13:0] uid;
	} nvc_state_s;

	nvc_state_s state_reg;
	nvc_state_s state_next;

	// ----------------------------------------------------------------
	// address permissions
	// ----------------------------------------------------------------
	function automatic logic [15:0] cfg_addr(input logic [14:0] a);
		cfg_addr = nvc_pkg::CFG_REGION_BASE | {1'b0, a};
	endfunction

	function automatic logic is_uid(input logic [15:0] a);
		is_uid = (a >= nvc_pkg::CFG_UID_FIRST) &&
			(a <= nvc_pkg::CFG_UID_LAST);
	endfunction

	function automatic logic cfg_readable(input logic [15:0] a);
		cfg_readable = is_uid(a) || (a == nvc_pkg::CFG_DEVICE_ID) ||
			(a == nvc_pkg::CFG_WORD1) || (a == nvc_pkg::CFG_WORD2);
	endfunction

	function automatic logic cfg_writable(input logic [15:0] a);
		cfg_writable = is_uid(a);
	endfunction

	logic [15:0] caddr;
	logic [1:0] uidx;
	logic idle;
	logic any_start;

	assign caddr = cfg_addr(addr_in);
	assign uidx = addr_in[1:0];
	assign idle = (state_reg.st == nvc_pkg::NVC_IDLE);
	assign any_start = read_start_in || write_start_in || erase_start_in;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [13:0] word;
		word = nvc_pkg::WORD_ZERO;
		state_next = state_reg;
		case (state_reg.st)
			nvc_pkg::NVC_IDLE: begin
				if (any_start) begin
					state_next.rej = 1'b0;
				end
				if (config_space_select_in && read_start_in) begin
					if (cfg_readable(caddr)) begin
						if (is_uid(caddr)) begin
							word = state_reg.uid[uidx];
						end else if (caddr == nvc_pkg::CFG_DEVICE_ID) begin
							word = DEVICE_ID;
						end else if (caddr == nvc_pkg::CFG_WORD1) begin
							word = cfg_word1_in;
						end else begin
							word = cfg_word2_in;
						end
					end else begin
						word = nvc_pkg::WORD_ZERO;
					end
					state_next.dh = word[13:8];
					state_next.dl = word[7:0];
				end else if (config_space_select_in && write_start_in) begin
					if (cfg_writable(caddr)) begin
						state_next.uid[uidx] = wdata_in;
					end else begin
						state_next.rej = 1'b1;
					end
				end else if (config_space_select_in && erase_start_in) begin
					if (cfg_writable(caddr)) begin
						state_next.uid = {nvc_pkg::UID_COUNT{nvc_pkg::WORD_ERASED}};
					end else begin
						state_next.rej = 1'b1;
					end
				end else if (any_start) begin
					state_next.st = nvc_pkg::NVC_FLASH_WAIT;
					state_next.busy = 1'b1;
					state_next.req = 1'b1;
					state_next.faddr = addr_in;
					state_next.fwd = wdata_in;
					if (read_start_in) begin
						state_next.cmd = nvc_pkg::FCMD_READ;
					end else if (write_start_in) begin
						state_next.cmd = nvc_pkg::FCMD_WRITE;
					end else begin
						state_next.cmd = nvc_pkg::FCMD_ERASE;
					end
				end
			end
			nvc_pkg::NVC_FLASH_WAIT: begin
				if (flash_done_in) begin
					state_next.st = nvc_pkg::NVC_IDLE;
					state_next.busy = 1'b0;
					state_next.req = 1'b0;
					if (state_reg.cmd == nvc_pkg::FCMD_READ) begin
						state_next.dh = flash_rdata_in[13:8];
						state_next.dl = flash_rdata_in[7:0];
					end
				end
			end
			default: begin
				state_next.st = nvc_pkg::NVC_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			state_reg <= '{st: nvc_pkg::NVC_IDLE, dh: 6'h00, dl: 8'h00,
				busy: 1'b0, rej: 1'b0, req: 1'b0, cmd: nvc_pkg::FCMD_READ,
				faddr: 15'h0000, fwd: nvc_pkg::WORD_ZERO,
				uid: {nvc_pkg::UID_COUNT{nvc_pkg::WORD_ERASED}}};
		end else begin
			state_reg <= state_next;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign flash_req_out = state_reg.req;
	assign flash_cmd_out = state_reg.cmd;
	assign flash_addr_out = state_reg.faddr;
	assign flash_wdata_out = state_reg.fwd;
	assign nvm_data_high_out = state_reg.dh;
	assign nvm_data_low_out = state_reg.dl;
	assign busy_out = state_reg.busy;
	assign write_reject_out = state_reg.rej;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);

	cfg_no_flash_a: assert property (
		idle && config_space_select_in && any_start |=> !flash_req_out
	) else $error("configuration access reached the flash macro");

	prog_to_flash_a: assert property (
		idle && !config_space_select_in && read_start_in |=>
			flash_req_out && flash_cmd_out == nvc_pkg::FCMD_READ &&
			busy_out
	) else $error("program read did not start a flash read");

	region_map_a: assert property (
		idle && config_space_select_in && read_start_in &&
			caddr == nvc_pkg::CFG_WORD1 |=>
			{nvm_data_high_out, nvm_data_low_out} == $past(cfg_word1_in)
	) else $error("configuration word 1 not mapped at its address");

	bad_read_zero_a: assert property (
		idle && config_space_select_in && read_start_in &&
			!cfg_readable(caddr) |=>
			nvm_data_high_out == 6'h00 && nvm_data_low_out == 8'h00
	) else $error("unlisted configuration read did not clear data");

	uid_roundtrip_a: assert property (
		idle && config_space_select_in && write_start_in &&
			is_uid(caddr) ##1 idle && config_space_select_in &&
			read_start_in && addr_in == $past(addr_in) |=>
			{nvm_data_high_out, nvm_data_low_out} == $past(wdata_in, 2)
	) else $error("user ID did not read back the written word");

	devid_read_only_a: assert property (
		idle && config_space_select_in && write_start_in &&
			caddr == nvc_pkg::CFG_DEVICE_ID |=>
			write_reject_out && $stable(state_reg.uid)
	) else $error("device ID write was not rejected");

	cfgword_read_only_a: assert property (
		idle && config_space_select_in && write_start_in &&
			(caddr == nvc_pkg::CFG_WORD1 || caddr == nvc_pkg::CFG_WORD2)
			|=> write_reject_out && !flash_req_out && !busy_out
	) else $error("configuration word write was not rejected");

	reject_no_cycle_a: assert property (
		idle && config_space_select_in && !read_start_in &&
			(write_start_in || erase_start_in) && !cfg_writable(caddr)
			|=> !flash_req_out && !busy_out && $stable(state_reg.uid)
	) else $error("rejected write changed storage or started a cycle");

endmodule

`default_nettype wire

// >>> logic/nvc_pkg.sv
// constants for the nonvolatile configuration-space access block
`default_nettype none
package nvc_pkg;

	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int ADDR_W = 15;
	localparam int WORD_W = 14;
	localparam int DATA_HIGH_W = 6;
	localparam int DATA_LOW_W = 8;
	localparam int UID_COUNT = 4;

	// ----------------------------------------------------------------
	// configuration region map
	// ----------------------------------------------------------------
	localparam logic [15:0] CFG_REGION_BASE = 16'h8000;
	localparam logic [15:0] CFG_UID_FIRST = 16'h8000;
	localparam logic [15:0] CFG_UID_LAST = 16'h8003;
	localparam logic [15:0] CFG_DEVICE_ID = 16'h8006;
	localparam logic [15:0] CFG_WORD1 = 16'h8007;
	localparam logic [15:0] CFG_WORD2 = 16'h8008;

	// ----------------------------------------------------------------
	// reset and erased values
	// ----------------------------------------------------------------
	localparam logic [13:0] WORD_ERASED = 14'h3FFF;
	localparam logic [13:0] WORD_ZERO = 14'h0000;

	// ----------------------------------------------------------------
	// flash macro commands
	// ----------------------------------------------------------------
	localparam logic [1:0] FCMD_READ = 2'h0;
	localparam logic [1:0] FCMD_WRITE = 2'h1;
	localparam logic [1:0] FCMD_ERASE = 2'h2;

	typedef enum logic [0:0] {
		NVC_IDLE = 1'b0,
		NVC_FLASH_WAIT = 1'b1
	} nvc_state_e;

endpackage

`default_nettype wire

// >>> verif/nvc_access_tb_top.sv
// self-checking testbench for the configuration-space access block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
	$display("MISMATCH t=%0t got %h exp %h", $time, (g), (e)); end end

module nvc_access_tb_top;
	// arbitrary identification value
	localparam logic [13:0] DEV_ID = 14'h1A5;
	localparam logic [13:0] CW1 = 14'h2A5C;
	localparam logic [13:0] CW2 = 14'h15A3;
	logic clk_in = 1'b0;
	logic reset_n_in = 1'b0;
	logic sel = 1'b0, rd = 1'b0, wr = 1'b0, er = 1'b0, done = 1'b0;
	logic [14:0] addr = 15'h0000;
	logic [13:0] wdata = 14'h0000, frd = 14'h0000;
	logic req, busy, rej;
	logic [1:0] cmd;
	logic [14:0] faddr;
	logic [13:0] fwd;
	logic [5:0] dh;
	logic [7:0] dl;
	int n_fail = 0;
	int total_checks = 0;

	nvc_access #(.DEVICE_ID(DEV_ID)) i_nvc_access (.clk_in(clk_in),
		.reset_n_in(reset_n_in), .config_space_select_in(sel),
		.read_start_in(rd), .write_start_in(wr), .erase_start_in(er),
		.addr_in(addr), .wdata_in(wdata), .cfg_word1_in(CW1),
		.cfg_word2_in(CW2), .flash_done_in(done), .flash_rdata_in(frd),
		.flash_req_out(req), .flash_cmd_out(cmd), .flash_addr_out(faddr),
		.flash_wdata_out(fwd), .nvm_data_high_out(dh),
		.nvm_data_low_out(dl), .busy_out(busy), .write_reject_out(rej));

	always #12.5 clk_in = ~clk_in;

	task automatic finish_test();
		if (n_fail == 0 && total_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	// one start pulse, outputs sampled 1 ns after the edge that takes it
	task automatic go(input logic s, input int k, input logic [14:0] a,
		input logic [13:0] d);
		@(posedge clk_in);
		sel <= s;
		addr <= a;
		wdata <= d;
		rd <= (k == 0);
		wr <= (k == 1);
		er <= (k == 2);
		@(posedge clk_in);
		rd <= 1'b0;
		wr <= 1'b0;
		er <= 1'b0;
		#1;
	endtask

	task automatic rdc(input logic [14:0] a, input logic [13:0] e);
		go(1'b1, 0, a, 14'h0000);
		`CHK({dh, dl, rej, req}, {e, 2'b00})
	endtask

	task automatic wrc(input int k, input logic [14:0] a, input logic ok);
		go(1'b1, k, a, 14'h0ABC);
		`CHK({rej, req, busy}, {~ok, 2'b00})
	endtask

	// flash operation with the macro answering dly+1 cycles after the request
	task automatic fop(input int k, input logic [14:0] a,
		input logic [13:0] d, input int dly);
		go(1'b0, k, a, d);
		`CHK({req, busy, cmd, faddr}, {2'b11, k[1:0], a})
		if (k == 1) `CHK(fwd, d)
		repeat (dly) @(posedge clk_in);
		#1;
		`CHK({req, busy, cmd}, {2'b11, k[1:0]})
		@(posedge clk_in);
		done <= 1'b1;
		frd <= d;
		@(posedge clk_in);
		done <= 1'b0;
		frd <= ~d;
		#1;
		`CHK({req, busy}, 2'b00)
		if (k == 0) `CHK({dh, dl}, d)
	endtask

	task automatic t_reset();
		`CHK({req, busy, rej, dh, dl, cmd}, 19'h00000)
		for (int i = 0; i < 4; i++) rdc(15'(i), 14'h3FFF);
	endtask

	task automatic t_read();
		rdc(15'h0006, DEV_ID);
		rdc(15'h0007, CW1);
		rdc(15'h0008, CW2);
		rdc(15'h0004, 14'h0000);
		rdc(15'h0007, CW1);
		rdc(15'h0005, 14'h0000);
		rdc(15'h0008, CW2);
		rdc(15'h0009, 14'h0000);
		rdc(15'h0006, DEV_ID);
		rdc(15'h7FFF, 14'h0000);
	endtask

	task automatic t_write();
		for (int i = 0; i < 4; i++) wrc(1, 15'(i), 1'b1);
		rdc(15'h0003, 14'h0ABC);
		wrc(1, 15'h0006, 1'b0);
		rdc(15'h0006, DEV_ID);
		wrc(1, 15'h0007, 1'b0);
		rdc(15'h0007, CW1);
		wrc(1, 15'h0008, 1'b0);
		wrc(2, 15'h0004, 1'b0);
		rdc(15'h0008, CW2);
		rdc(15'h0000, 14'h0ABC);
		wrc(2, 15'h0002, 1'b1);
		for (int i = 0; i < 4; i++) rdc(15'(i), 14'h3FFF);
	endtask

	// user ID write and read taken on consecutive edges
	task automatic t_b2b();
		@(posedge clk_in);
		sel <= 1'b1;
		addr <= 15'h0001;
		wdata <= 14'h1357;
		wr <= 1'b1;
		@(posedge clk_in);
		wr <= 1'b0;
		rd <= 1'b1;
		wdata <= 14'h0000;
		@(posedge clk_in);
		rd <= 1'b0;
		#1;
		`CHK({dh, dl, rej, req}, {14'h1357, 2'b00})
		rdc(15'h0000, 14'h3FFF);
		rdc(15'h0002, 14'h3FFF);
	endtask

	// row rewrite in software order: read, erase, reload and program
	task automatic t_row();
		fop(0, 15'h0140, 14'h1234, 0);
		fop(0, 15'h0141, 14'h2B6D, 3);
		fop(2, 15'h0140, 14'h0000, 2);
		fop(1, 15'h0140, 14'h1235, 1);
		fop(1, 15'h0141, 14'h2B6D, 4);
	endtask

	initial begin
		repeat (12) @(posedge clk_in);
		reset_n_in <= 1'b1;
		@(posedge clk_in);
		#1;
		t_reset();
		t_read();
		t_write();
		t_b2b();
		t_row();
		finish_test();
	end

	initial begin
		repeat (3000) @(posedge clk_in);
		n_fail++;
		finish_test();
	end
endmodule

`default_nettype wire
